// ===== verilog/spbc_ctrl.sv
// spbc_ctrl: processor-side control for slow synchronous peripherals.
// assumes the core presents one request at a time and holds it to ack.
//
// What this block does
// RULE1: enable clock period ten, six low four high
// RULE2: ring counter start phase is arbitrary
// RULE3: enable runs always, whatever the bus does
// RULE4: sync request makes transfer follow enable clock
// RULE5: sync request in interrupt ack means autovector
// RULE6: valid only after address and enable sync
// RULE7: valid only in sync peripheral cycles
// RULE8: space code encodes privilege and space type
// RULE9: space code held while strobe asserted
// RULE10: system keeps processor clock running always
// RULE11: low mode strap at reset selects byte bus
// RULE12: sync request in wait state converts cycle
// RULE13: halt stops after cycle, three-state lines stay driven
// RULE14: relinquish floats bus, enable and grant stay
// RULE15: valid negates when sync cycle ends
`timescale 1ns/1ps
module spbc_ctrl
   import spbc_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk,
   input  wire logic                arst_n,
   // core request side
   input  wire logic                core_req,      // level, held to done
   input  wire spbc_pkg::spbc_req_t core_info,     // access description
   output logic                     core_done_q,   // one-cycle pulse
   output logic                     core_fault_q,  // one cycle before done: fault
   output logic                     core_avec_q,   // one cycle before done: autovector
   // pins from outside, asynchronous
   input  wire logic                periph_sync_req_n,
   input  wire logic                xfer_ack_n,
   input  wire logic                bus_fault_n,
   input  wire logic                halt_req_n,
   input  wire logic                relinquish_n,   // bus granted away
   input  wire logic                mode_strap,
   // pins to outside
   output logic                     periph_ena_q,
   output logic                     addr_strobe_n_q,
   output logic                     addr_strobe_oe_q,
   output logic [2:0]               space_code_q,
   output logic                     space_code_oe_q,
   output logic                     sync_addr_valid_n_q,
   output logic                     sync_addr_valid_oe_q,
   output logic                     byte_mode_q,
   output logic                     halted_q
);

   ////////////////////////////////////////////////////////////////////////
   // enable generator, free running: nothing here may stall it
   logic ena;         // enable level
   logic ena_fall;    // enable about to fall
   logic ena_rise;    // enable about to rise

   spbc_ring u_ring (               // see RULE3
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .ena_q      (ena),
      .ena_fall_q (ena_fall),
      .ena_rise_q (ena_rise)
   );

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         periph_ena_q <= 1'b0;
      end else begin
         periph_ena_q <= ena;       // see RULE1
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers for every pin input
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] pin_raw;       // raw pin levels
   logic [NSYNC-1:0] meta_q;        // first stage, read by stage two only
   logic [NSYNC-1:0] pin_q;         // settled levels

   assign pin_raw = {mode_strap, relinquish_n, halt_req_n,
                     bus_fault_n, xfer_ack_n, periph_sync_req_n};

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= {NSYNC{1'b1}};
         pin_q  <= {NSYNC{1'b1}};
      end else begin
         meta_q <= pin_raw;
         pin_q  <= meta_q;
      end
   end

   logic psync_s, ack_s, fault_s, halt_s, relq_s, mode_s;
   assign {mode_s, relq_s, halt_s, fault_s, ack_s, psync_s} =
          {pin_q[5], ~pin_q[4], ~pin_q[3], ~pin_q[2], ~pin_q[1], ~pin_q[0]};

   ////////////////////////////////////////////////////////////////////////
   // bus width strap, taken once the synchroniser holds a post-reset
   // sample; its flops are reset too, so earlier they show only 16-bit
   logic       strap_done_q;        // strap already taken
   logic [1:0] strap_wait_q;        // release age, one bit per sync stage

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_done_q <= 1'b0;
         strap_wait_q <= 2'h0;
         byte_mode_q  <= BYTE_MODE_RST;
      end else begin
         strap_wait_q <= {strap_wait_q[0], 1'b1};
         // both stages now carry the pin as seen after release
         if (strap_wait_q[1] && !strap_done_q) begin
            strap_done_q <= 1'b1;
            byte_mode_q  <= ~mode_s;   // see RULE11
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus cycle sequencer
   typedef enum logic [2:0] {
      ST_IDLE,      // no cycle
      ST_ADDR,      // code and address out
      ST_WAIT,      // waiting for ack, fault or sync request
      ST_SYNC,      // wait for enable about to rise, then drive valid
      ST_PHIGH,     // valid out, wait through enable high phase
      ST_END,       // strobes negate
      ST_HALT       // stopped between cycles
   } spbc_state_t;

   spbc_state_t state_q;
   logic        avec_q;             // this sync cycle is an autovector
   logic [2:0]  code_q;             // space code held for the cycle

   // space code from privilege and access kind
   function automatic logic [2:0] code_of(input spbc_req_t r);
      unique case (r.kind)
         SPBC_ACC_IACK: code_of = SC_CPU_SPACE;
         SPBC_ACC_PROG: code_of = r.supervisor ? SC_SUPV_PROG : SC_USER_PROG;
         default:       code_of = r.supervisor ? SC_SUPV_DATA : SC_USER_DATA;
      endcase
   endfunction

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q      <= ST_IDLE;
         avec_q       <= 1'b0;
         code_q       <= SC_IDLE;
         core_done_q  <= 1'b0;
         core_fault_q <= 1'b0;
         core_avec_q  <= 1'b0;
      end else begin
         core_done_q  <= 1'b0;
         core_fault_q <= 1'b0;
         core_avec_q  <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (halt_s) begin
                  state_q <= ST_HALT;                       // see RULE13
               end else if (core_req && !relq_s && !core_done_q) begin
                  code_q  <= code_of(core_info);            // see RULE8
                  state_q <= ST_ADDR;
               end
            end
            ST_ADDR: state_q <= ST_WAIT;
            ST_WAIT: begin
               if (fault_s) begin
                  core_fault_q <= 1'b1;
                  state_q      <= ST_END;
               end else if (ack_s) begin
                  state_q <= ST_END;
               end else if (psync_s) begin                  // see RULE12
                  // interrupt ack with sync request: no vector read
                  avec_q  <= (code_q == SC_CPU_SPACE);      // see RULE5
                  state_q <= ST_SYNC;                       // see RULE4
               end
            end
            ST_SYNC: begin
               // wait for a rising edge so valid spans a full high phase
               if (ena_rise) begin
                  state_q <= ST_PHIGH;                      // see RULE6
               end
            end
            ST_PHIGH: begin
               if (ena_fall) begin
                  core_avec_q <= avec_q;
                  state_q     <= ST_END;                    // see RULE15
               end
            end
            ST_END: begin
               core_done_q <= 1'b1;
               avec_q      <= 1'b0;
               state_q     <= halt_s ? ST_HALT : ST_IDLE;   // see RULE13
            end
            ST_HALT: begin
               if (!halt_s) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drive; strobe stands from ADDR to PHIGH, code from ADDR to END inclusive
   spbc_pins_t pins_d;              // next pin values
   logic       in_cycle;            // strobe asserted states

   always_comb begin
      in_cycle = (state_q == ST_WAIT) || (state_q == ST_SYNC) ||
                 (state_q == ST_PHIGH) || (state_q == ST_ADDR);
      pins_d.strobe_n  = ~in_cycle;
      pins_d.code      = (in_cycle || state_q == ST_END) ? code_q : SC_IDLE;
      // valid only in the synchronised high phase                see RULE7
      pins_d.valid_n   = ~(state_q == ST_PHIGH);
      // relinquish floats the bus group; halt keeps controls driven
      pins_d.strobe_oe = ~relq_s;                            // see RULE14
      pins_d.code_oe   = ~relq_s;
      pins_d.valid_oe  = ~relq_s;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_strobe_n_q      <= 1'b1;
         addr_strobe_oe_q     <= 1'b1;
         space_code_q         <= SC_IDLE;
         space_code_oe_q      <= 1'b1;
         sync_addr_valid_n_q  <= 1'b1;
         sync_addr_valid_oe_q <= 1'b1;
         halted_q             <= 1'b0;
      end else begin
         addr_strobe_n_q      <= pins_d.strobe_n;
         addr_strobe_oe_q     <= pins_d.strobe_oe;
         space_code_q         <= pins_d.code;               // see RULE9
         space_code_oe_q      <= pins_d.code_oe;
         sync_addr_valid_n_q  <= pins_d.valid_n;
         sync_addr_valid_oe_q <= pins_d.valid_oe;
         halted_q             <= (state_q == ST_HALT);      // see RULE13
      end
   end

endmodule

// ===== include/spbc_pkg.sv
// spbc_pkg: constants, codes and carrier structs for the sync peripheral
// bus controller. assumes a single processor clock domain.
package spbc_pkg;

   // enable clock shape, in processor clocks
   localparam int ENA_PERIOD   = 10;    // whole enable period
   localparam int ENA_LOW_CLKS = 6;     // low phase length
   localparam int ENA_HIGH_CLKS = 4;    // high phase length

   // space code encodings
   localparam logic [2:0] SC_USER_DATA  = 3'h1;
   localparam logic [2:0] SC_USER_PROG  = 3'h2;
   localparam logic [2:0] SC_SUPV_DATA  = 3'h5;
   localparam logic [2:0] SC_SUPV_PROG  = 3'h6;
   localparam logic [2:0] SC_CPU_SPACE  = 3'h7;
   localparam logic [2:0] SC_IDLE       = 3'h0;

   // reset value of the bus width strap: 16-bit mode
   localparam logic BYTE_MODE_RST = 1'b0;

   // access kinds requested by the core
   typedef enum logic [1:0] {
      SPBC_ACC_DATA,
      SPBC_ACC_PROG,
      SPBC_ACC_IACK
   } spbc_acc_t;

   // one bus request from the core side
   typedef struct packed {
      logic      supervisor;   // privilege of the access
      spbc_acc_t kind;         // data, program or interrupt ack
   } spbc_req_t;

   // three-state control outputs with their enables
   typedef struct packed {
      logic       strobe_n;    // address strobe level
      logic       strobe_oe;   // address strobe enable
      logic [2:0] code;        // space code level
      logic       code_oe;     // space code enable
      logic       valid_n;     // sync address valid level
      logic       valid_oe;    // sync address valid enable
   } spbc_pins_t;

endpackage

// ===== verilog/spbc_ring.sv
// spbc_ring: free-running ring counter that shapes the peripheral enable.
// assumes one processor clock that never stops.
`timescale 1ns/1ps
module spbc_ring #(
   parameter int PERIOD = spbc_pkg::ENA_PERIOD,
   parameter int LOW    = spbc_pkg::ENA_LOW_CLKS
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic arst_n,
   // enable outputs
   output logic      ena_q,         // peripheral enable level
   output logic      ena_fall_q,    // last high clock before falling
   output logic      ena_rise_q     // last low clock before rising
);
   import spbc_pkg::*;

   // elaboration check: each phase needs at least one slot of the ring
   if (LOW < 1 || LOW >= PERIOD) begin
      $error("spbc_ring: low phase must fit inside period");
   end

   ////////////////////////////////////////////////////////////////////////
   // one-hot ring; reset seeds one slot, no phase promise to the bus
   logic [PERIOD-1:0] ring_q;       // rotating single token

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ring_q <= {{(PERIOD-1){1'b0}}, 1'b1};
      end else begin
         ring_q <= {ring_q[PERIOD-2:0], ring_q[PERIOD-1]}; // see RULE2
      end
   end

   // token in slots LOW..PERIOD-1 means high; registered outputs
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ena_q      <= 1'b0;
         ena_fall_q <= 1'b0;
         ena_rise_q <= 1'b0;
      end else begin
         ena_q      <= |ring_q[PERIOD-2:LOW-1];       // see RULE1
         ena_rise_q <= ring_q[LOW-2 < 0 ? PERIOD-1 : LOW-2];
         ena_fall_q <= ring_q[PERIOD-2];
      end
   end

endmodule

// ===== tb/spbc_ctrl_props.sv
// spbc_ctrl_props: pin timing checks for the sync peripheral controller.
// assumes one processor clock; bound onto every spbc_ctrl instance.
`timescale 1ns/1ps
module spbc_ctrl_props
   import spbc_pkg::*;
(
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       arst_n,
   // watched pins
   input wire logic       periph_sync_req_n,
   input wire logic       core_avec_q,
   input wire logic       core_done_q,
   input wire logic       periph_ena_q,
   input wire logic       addr_strobe_n_q,
   input wire logic [2:0] space_code_q,
   input wire logic       sync_addr_valid_n_q,
   input wire logic       halted_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////
   // enable high phase, four clocks then a fall
   sequence s_high4; periph_ena_q[*4] ##1 !periph_ena_q; endsequence
   // valid low for the whole high phase only
   sequence s_valid4; (!sync_addr_valid_n_q)[*4] ##1 sync_addr_valid_n_q;
   endsequence
   a_ena_period: assert property (
      $fell(periph_ena_q) |-> ##10 $fell(periph_ena_q))
      else $error("enable period is not ten clocks");
   a_ena_high_four: assert property (
      $rose(periph_ena_q) |-> s_high4) else $error("enable high not four");
   a_valid_gate: assert property (
      !sync_addr_valid_n_q |-> periph_ena_q && !addr_strobe_n_q)
      else $error("valid outside strobe or enable high");
   a_valid_four: assert property (
      $fell(sync_addr_valid_n_q) |-> $rose(periph_ena_q) ##0 s_valid4)
      else $error("valid not aligned to enable high phase");
   a_valid_cause: assert property (
      $fell(sync_addr_valid_n_q) |-> !$past(periph_sync_req_n, 2))
      else $error("valid without a sync request");
   a_valid_ends: assert property (
      $rose(sync_addr_valid_n_q) |-> $rose(addr_strobe_n_q))
      else $error("valid did not end with the cycle");
   a_code_legal: assert property (
      !addr_strobe_n_q |-> space_code_q inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7})
      else $error("reserved space code under strobe");
   a_code_held: assert property (
      !addr_strobe_n_q && !$past(addr_strobe_n_q) |-> $stable(space_code_q))
      else $error("space code moved under strobe");
   a_avec_done: assert property (
      core_avec_q |=> core_done_q) else $error("autovector without done");
   a_halt_quiet: assert property (
      halted_q |-> addr_strobe_n_q && sync_addr_valid_n_q)
      else $error("controls active while halted");
endmodule
bind spbc_ctrl spbc_ctrl_props i_props (.ref_clk(ref_clk), .arst_n(arst_n),
   .periph_sync_req_n(periph_sync_req_n), .core_avec_q(core_avec_q),
   .core_done_q(core_done_q), .periph_ena_q(periph_ena_q),
   .addr_strobe_n_q(addr_strobe_n_q), .space_code_q(space_code_q),
   .sync_addr_valid_n_q(sync_addr_valid_n_q), .halted_q(halted_q));

// ===== tb/spbc_periph_model.sv
// spbc_periph_model: slow peripheral plus decoder on the far side.
// assumes the strobe it sees is already resolved to a wire level.
`timescale 1ns/1ps
module spbc_periph_model (
   // clock and strobe
   input  wire logic       ref_clk,
   input  wire logic       strobe_n,
   // answer kind 0 ack, 1 sync, 2 fault; clocks before answering
   input  wire logic [1:0] mode,
   input  wire logic [2:0] delay,
   // answer lines, pulled up when released
   output logic            sync_req_n,
   output logic            ack_n,
   output logic            fault_n
);
   int cnt;
   initial begin
      sync_req_n = 1;
      ack_n = 1;
      fault_n = 1;
      cnt = 0;
   end
   // answer after the delay, hold until strobe goes away
   always @(posedge ref_clk) begin
      #1;
      if (strobe_n !== 1'b0) begin // released lines float to the pull-up
         cnt = 0;
         {sync_req_n, ack_n, fault_n} = 3'h7;
      end else if (cnt < delay) begin
         cnt++;
      end else begin // decode flags slow parts
         sync_req_n = (mode != 2'h1);
         ack_n = (mode != 2'h0);
         fault_n = (mode != 2'h2);
      end
   end
endmodule

// ===== tb/spbc_ctrl_tb.sv
// spbc_ctrl_tb: corner and random bus cycles through spbc_ctrl.
// assumes the peripheral model answers on the far side of the pins.
`timescale 1ns/1ps
module spbc_ctrl_tb;
   import spbc_pkg::*;
   logic       ref_clk, arst_n, core_req, strap, halt_n, rel_n, hi, prev;
   spbc_req_t  info;
   logic       done, fault, avec, ena, st_n, st_oe, sc_oe, va_n, va_oe;
   logic       byte_m, halted, sync_n, ack_n, flt_n;
   logic [2:0] code, dly;
   logic [1:0] pm;
   int         n_fail, checks, i, n;
   wire        st_w = st_oe ? st_n : 1'b1; // pulled up when floated
   initial begin // the clock never stops
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   spbc_ctrl i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .core_req(core_req),
      .core_info(info), .core_done_q(done), .core_fault_q(fault),
      .core_avec_q(avec), .periph_sync_req_n(sync_n), .xfer_ack_n(ack_n),
      .bus_fault_n(flt_n), .halt_req_n(halt_n), .relinquish_n(rel_n),
      .mode_strap(strap), .periph_ena_q(ena), .addr_strobe_n_q(st_n),
      .addr_strobe_oe_q(st_oe), .space_code_q(code), .space_code_oe_q(sc_oe),
      .sync_addr_valid_n_q(va_n), .sync_addr_valid_oe_q(va_oe),
      .byte_mode_q(byte_m), .halted_q(halted));
   spbc_periph_model i_periph (.ref_clk(ref_clk), .strobe_n(st_w),
      .mode(pm), .delay(dly), .sync_req_n(sync_n), .ack_n(ack_n),
      .fault_n(flt_n));
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk3(input string nm, input logic [2:0] e,
                       input logic [2:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // expected space code from privilege and kind
   function automatic logic [2:0] exp_code(input spbc_req_t r);
      if (r.kind == SPBC_ACC_IACK) return 3'h7;
      return {r.supervisor, r.kind == SPBC_ACC_PROG, r.kind == SPBC_ACC_DATA};
   endfunction
   task automatic do_reset(input logic s);
      arst_n = 0;
      strap = s; // held from reset through release
      repeat (10) @(posedge ref_clk);
      #1 arst_n = 1;
      repeat (5) @(posedge ref_clk);
      #1 chk1("byte_mode_q", ~s, byte_m);
   endtask
   // one whole cycle; the far side answers with kind m after d clocks
   task automatic bus_cycle(input spbc_req_t r, input logic [1:0] m,
                            input logic [2:0] d);
      logic sv, av, fl, seen, iack;
      sv = 0; av = 0; fl = 0; seen = 0;
      iack = (r.kind == SPBC_ACC_IACK);
      pm = m; dly = d; info = r; core_req = 1;
      for (int k = 0; k < 80 && done !== 1'b1; k++) begin
         @(posedge ref_clk);
         #1;
         if (st_n === 1'b0 && !seen)
            chk3("space_code_q", exp_code(r), code);
         seen |= (st_n === 1'b0);
         sv |= (va_n === 1'b0);
         av |= (avec === 1'b1);
         fl |= (fault === 1'b1); // fault pulse leads done by one cycle
      end
      core_req = 0;
      chk1("core_done_q", 1'b1, done);
      chk1("core_fault_q", m == 2'h2, fl);
      chk1("core_avec_q", m == 2'h1 && iack, av);
      chk1("sync_addr_valid_n_q", m == 2'h1, sv);
      @(posedge ref_clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(69));
      n_fail = 0; checks = 0; core_req = 0; info = '0; halt_n = 1;
      rel_n = 1; pm = 0; dly = 0;
      do_reset(1'b1);
      for (i = 0; i < 6; i++) begin // all five codes, all answer kinds
         info = '{i[0], spbc_acc_t'(2'(i / 2))};
         bus_cycle(info, 2'(i % 3), 3'(i));
      end
      bus_cycle('{1'b1, SPBC_ACC_IACK}, 2'h1, 3'h0);
      bus_cycle('{1'b0, SPBC_ACC_IACK}, 2'h1, 3'h7);
      for (i = 0; i < 12; i++) // random traffic
         bus_cycle('{1'($urandom), spbc_acc_t'(2'($urandom_range(2)))},
                   2'($urandom_range(2)), 3'($urandom));
      halt_n = 0; // request arrives while stopped
      repeat (4) @(posedge ref_clk);
      #1 info = '{1'b0, SPBC_ACC_PROG};
      core_req = 1;
      hi = 1;
      repeat (20) begin
         @(posedge ref_clk);
         #1 hi &= (st_n === 1'b1);
      end
      chk1("halted_q", 1'b1, halted);
      chk1("addr_strobe_n_q", 1'b1, hi);
      halt_n = 1; // the held request must now complete
      bus_cycle('{1'b0, SPBC_ACC_PROG}, 2'h0, 3'h2);
      rel_n = 0;
      repeat (4) @(posedge ref_clk);
      #1 prev = ena;
      n = 0;
      repeat (20) begin
         @(posedge ref_clk);
         #1 n += (ena !== prev);
         prev = ena;
      end
      chk1("enable edges", 1'b1, n == 4);
      chk1("addr_strobe_oe_q", 1'b0, st_oe);
      chk1("space_code_oe_q", 1'b0, sc_oe);
      chk1("sync_addr_valid_oe_q", 1'b0, va_oe);
      rel_n = 1;
      bus_cycle('{1'b1, SPBC_ACC_DATA}, 2'h0, 3'h1);
      do_reset(1'b0);
      bus_cycle('{1'b1, SPBC_ACC_DATA}, 2'h1, 3'h3);
      give_verdict;
   end
   initial begin // cut a hang short
      #200000;
      n_fail++;
      give_verdict;
   end
endmodule
